/* File: core/strap_pin_params.svh */
// constants for the shared memory-pin and strap controller
// assumes nothing; definitions only
`ifndef STRAP_PIN_PARAMS_SVH
`define STRAP_PIN_PARAMS_SVH

`define MEM_ADDR_W        16
`define MEM_DATA_W        8
`define MEM_UPPER_LSB     3
`define MEM_LOW_W         2
// address bit that shares its pin with the clock-mode strap
`define MEM_BIT2_POS      2
// synchroniser width: data bus, bit3, bit2, two low bits
`define PIN_SYNC_W        12
`define SYNC_DATA_LSB     0
`define SYNC_BIT3_POS     8
`define SYNC_BIT2_POS     9
`define SYNC_LOW_LSB      10
// strap values held before the first capture
`define IR_POL_RST        1'h1
`define CLK_MODE_RST      1'h0
`define FREQ_RST          2'h0
// strap code meaning
`define CLK_MODE_XTAL     1'h0
`define CLK_MODE_EXT      1'h1

`endif

/* File: core/strap_pin_pkg.sv */
// types shared by the strap and memory-pin controller
// assumes strap_pin_params.svh is on the include path
`include "strap_pin_params.svh"

package strap_pin_pkg;

  // frequency strap codes
  typedef enum logic [1:0] {
    FREQ_24MHZ  = 2'h0,
    FREQ_RSVD_1 = 2'h1,
    FREQ_RSVD_2 = 2'h2,
    FREQ_48MHZ  = 2'h3
  } freq_strap_t;

  // resolved clock selection
  typedef enum logic [1:0] {
    CLK_XTAL_24 = 2'h0,
    CLK_EXT_24  = 2'h1,
    CLK_EXT_48  = 2'h2,
    CLK_EXT_BAD = 2'h3
  } clk_select_t;

  // latched strap set
  typedef struct packed {
    logic        ir_led_polarity_strap;
    logic        clock_mode_strap;
    freq_strap_t freq_strap;
  } strap_t;

  // low-power condition inputs
  typedef struct packed {
    logic cpu_idle_bit;
    logic wake_interrupt;
    logic sleep_bit;
  } power_state_t;

endpackage : strap_pin_pkg

/* File: core/reset_strap_memory_pin_ctrl.sv */
// shared external program-memory pins, reset-time straps and low-power release of addr bit 2
// assumes a free-running I_CLK during reset and a pad ring that resolves in/out/oe_n and pulls
// assumes the cpu-side inputs and power bits come from logic on I_CLK; only pins are synced
// the pad pulls are weak; a board that drives a strap pin during reset overrides them
// strap pins double as address outputs, so every strap output is frozen once captured
// and the address pins follow the cpu from then on
`timescale 1ns/1ps
`include "strap_pin_params.svh"

module reset_strap_memory_pin_ctrl (
  // clock and reset
  input  wire logic                                   I_CLK,
  input  wire logic                                   I_RESETN,
  // cpu side
  input  wire logic [`MEM_ADDR_W-1:0]                 i_mem_addr,
  input  wire logic [`MEM_DATA_W-1:0]                 i_mem_wdata,
  input  wire logic                                   i_mem_write,
  input  wire logic                                   i_ext_rom_enable_bit,
  input  wire strap_pin_pkg::power_state_t            i_power_state,
  output logic      [`MEM_DATA_W-1:0]                 o_mem_rdata,
  // memory data bus pins
  input  wire logic [`MEM_DATA_W-1:0]                 i_mem_data_bus,
  output logic      [`MEM_DATA_W-1:0]                 o_mem_data_bus,
  output logic                                        o_mem_data_bus_oe_n,
  // address pins
  output logic      [`MEM_ADDR_W-1:`MEM_UPPER_LSB]    o_mem_addr_upper,
  input  wire logic                                   i_mem_addr_bit3,
  output logic                                        o_mem_addr_bit3_oe_n,
  input  wire logic                                   i_mem_addr_bit2,
  output logic                                        o_mem_addr_bit2,
  output logic                                        o_mem_addr_bit2_oe_n,
  input  wire logic [`MEM_LOW_W-1:0]                  i_mem_addr_low,
  output logic      [`MEM_LOW_W-1:0]                  o_mem_addr_low,
  output logic                                        o_mem_addr_low_oe_n,
  // pad pull controls
  output logic                                        o_bit3_pullup_en,
  output logic                                        o_bit2_pulldown_en,
  output logic                                        o_low_pulldown_en,
  // latched straps
  output strap_pin_pkg::strap_t                       o_straps,
  output strap_pin_pkg::clk_select_t                  o_clk_select,
  output logic                                        o_freq_reserved
);

  // synchroniser stages; left without reset so they keep sampling the straps during reset
  logic [`PIN_SYNC_W-1:0]      sync1_reg;
  logic [`PIN_SYNC_W-1:0]      sync1_next;
  logic [`PIN_SYNC_W-1:0]      sync2_reg;
  logic [`PIN_SYNC_W-1:0]      sync2_next;
  logic [`PIN_SYNC_W-1:0]      pin_raw;

  // strap capture state; captured_reg low means the pins still serve as straps,
  // released, with their pulls enabled
  logic                        captured_reg;
  logic                        captured_next;
  strap_pin_pkg::strap_t       strap_reg;
  strap_pin_pkg::strap_t       strap_next;

  // pin drive state; one register stage per pin and no buffering beyond it
  logic [`MEM_ADDR_W-1:0]      addr_reg;
  logic [`MEM_ADDR_W-1:0]      addr_next;
  logic [`MEM_DATA_W-1:0]      wdata_reg;
  logic [`MEM_DATA_W-1:0]      wdata_next;
  logic [`MEM_DATA_W-1:0]      rdata_reg;
  logic [`MEM_DATA_W-1:0]      rdata_next;
  logic                        data_oe_n_reg;
  logic                        data_oe_n_next;
  logic                        bit2_oe_n_reg;
  logic                        bit2_oe_n_next;
  logic                        bit2_float;
  logic                        low_power_req;
  logic                        mode_ext;

  // pin levels in synchroniser order: low bits, bit2, bit3, data bus
  assign pin_raw = {i_mem_addr_low, i_mem_addr_bit2, i_mem_addr_bit3, i_mem_data_bus};

  // synchroniser shift; only the second stage reads the first, so a metastable
  // first stage never fans out into the strap or read-data logic
  always_comb begin
    sync1_next = pin_raw;
    sync2_next = sync1_reg;
  end

  // two-flop synchroniser for every pin read back by the core
  always_ff @(posedge I_CLK) begin
    sync1_reg <= sync1_next;
    sync2_reg <= sync2_next;
  end

  // one capture at the first edge after release; sync2 still holds reset-time levels then
  // limitation: reset must span at least two clock edges, or sync2 may still hold a level
  // taken before the pulls had settled the pin
  // the capture waits for a clock edge so that no logic is clocked by the reset net
  always_comb begin
    captured_next = 1'h1;
    strap_next    = strap_reg;
    // one shot: once captured, strap_next only echoes strap_reg
    if (!captured_reg) begin
      strap_next.ir_led_polarity_strap = sync2_reg[`SYNC_BIT3_POS];
      strap_next.clock_mode_strap      = sync2_reg[`SYNC_BIT2_POS];
      strap_next.freq_strap            = strap_pin_pkg::freq_strap_t'(
                                         sync2_reg[`SYNC_LOW_LSB +: `MEM_LOW_W]);
    end
  end

  // straps freeze once captured; later pin activity is ignored
  // reset restores defaults that match the pull directions, so an open strap pin
  // and a strap that was never captured read the same
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      captured_reg                     <= 1'h0;
      strap_reg.ir_led_polarity_strap  <= `IR_POL_RST;
      strap_reg.clock_mode_strap       <= `CLK_MODE_RST;
      strap_reg.freq_strap             <= strap_pin_pkg::freq_strap_t'(`FREQ_RST);
    end else begin
      captured_reg <= captured_next;
      strap_reg    <= strap_next;
    end
  end

  // all three sleep conditions; wake is taken as active high, so negated means low
  assign low_power_req = i_power_state.cpu_idle_bit
                      && !i_power_state.wake_interrupt
                      && i_power_state.sleep_bit;

  // external clock mode; strap_next lets the capture cycle already see the new mode
  assign mode_ext = (strap_next.clock_mode_strap == `CLK_MODE_EXT);

  // bit2 may float only with an external clock and the core fully asleep;
  // with a crystal it stays an ordinary address output
  assign bit2_float = mode_ext && low_power_req;

  // next pin drive values, all released until the straps are captured
  // the data bus is driven on write cycles only: a read leaves it released so the memory
  // can answer, and rom enable 1 keeps it released whatever the cpu asks for
  always_comb begin
    addr_next      = i_mem_addr;
    wdata_next     = i_mem_wdata;
    rdata_next     = sync2_reg[`SYNC_DATA_LSB +: `MEM_DATA_W];
    data_oe_n_next = !(captured_next && !i_ext_rom_enable_bit && i_mem_write);
    bit2_oe_n_next = !captured_next || bit2_float;
  end

  // pin drive registers; reset leaves every strap pin released
  // values and enables come from flops so the pads never see combinational glitches,
  // at the cost of one cycle from cpu request to pin
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      addr_reg      <= 16'h0000;
      wdata_reg     <= 8'h00;
      rdata_reg     <= 8'h00;
      data_oe_n_reg <= 1'h1;
      bit2_oe_n_reg <= 1'h1;
    end else begin
      addr_reg      <= addr_next;
      wdata_reg     <= wdata_next;
      rdata_reg     <= rdata_next;
      data_oe_n_reg <= data_oe_n_next;
      bit2_oe_n_reg <= bit2_oe_n_next;
    end
  end

  // upper address pins other than bit3 are plain outputs and never released
  assign o_mem_addr_upper     = addr_reg[`MEM_ADDR_W-1:`MEM_UPPER_LSB];

  // bit3 is released only while its polarity strap is sampled; its value is upper bit 3
  assign o_mem_addr_bit3_oe_n = !captured_reg;

  // bit2 always carries the address; only its enable depends on the clock mode
  assign o_mem_addr_bit2      = addr_reg[`MEM_BIT2_POS];
  assign o_mem_addr_bit2_oe_n = bit2_oe_n_reg;

  // low pins hold the frequency strap in reset and address bits afterwards
  assign o_mem_addr_low       = addr_reg[`MEM_LOW_W-1:0];
  assign o_mem_addr_low_oe_n  = !captured_reg;

  // data pins: write data out, read data back through the synchroniser
  assign o_mem_data_bus       = wdata_reg;
  assign o_mem_data_bus_oe_n  = data_oe_n_reg;
  assign o_mem_rdata          = rdata_reg;

  // pulls only while the straps are being sampled
  // they drop with the output enables, so a pin is never pulled and driven for long
  assign o_bit3_pullup_en     = !captured_reg;
  assign o_bit2_pulldown_en   = !captured_reg;
  assign o_low_pulldown_en    = !captured_reg;

  // latched straps go out unchanged for the ir driver and the clock generator
  assign o_straps        = strap_reg;

  // reserved frequency codes are flagged, not corrected; firmware decides what follows
  assign o_freq_reserved = (strap_reg.freq_strap == strap_pin_pkg::FREQ_RSVD_1)
                         || (strap_reg.freq_strap == strap_pin_pkg::FREQ_RSVD_2);

  // clock select; a crystal runs at 24MHz whatever the frequency strap says, and an
  // external clock with a reserved code is reported as such rather than guessed at
  always_comb begin
    if (strap_reg.clock_mode_strap == `CLK_MODE_XTAL) begin
      o_clk_select = strap_pin_pkg::CLK_XTAL_24;
    end else if (strap_reg.freq_strap == strap_pin_pkg::FREQ_24MHZ) begin
      o_clk_select = strap_pin_pkg::CLK_EXT_24;
    end else if (strap_reg.freq_strap == strap_pin_pkg::FREQ_48MHZ) begin
      o_clk_select = strap_pin_pkg::CLK_EXT_48;
    end else begin
      // external clock with a reserved frequency code
      o_clk_select = strap_pin_pkg::CLK_EXT_BAD;
    end
  end

endmodule : reset_strap_memory_pin_ctrl

/* File: sim/ext_mem_model.sv */
// external program memory seen through the shared data pins
// assumes the bench resolves the pins; answers whenever the pins are released
`timescale 1ns/1ps
module ext_mem_model (
  // pins from the controller
  input  wire logic [12:0] i_addr,
  input  wire logic [7:0]  i_data,
  input  wire logic        i_oe_n,
  // resolved data pins
  output logic      [7:0]  o_data
);
  // contents are a fixed function of address, so no stale bus value can match
  assign o_data = i_oe_n ? (i_addr[7:0] ^ 8'h5A) : i_data;
endmodule : ext_mem_model

/* File: sim/reset_strap_memory_pin_ctrl_asserts.sv */
// port-level checks for the memory-pin and strap controller
// assumes a bind onto reset_strap_memory_pin_ctrl; single clock domain
`timescale 1ns/1ps
`include "strap_pin_params.svh"
module reset_strap_memory_pin_ctrl_asserts (
  // clock, reset and cpu side
  input wire logic                                I_CLK,
  input wire logic                                I_RESETN,
  input wire logic [`MEM_ADDR_W-1:0]              i_mem_addr,
  input wire logic [`MEM_DATA_W-1:0]              i_mem_wdata,
  input wire logic                                i_mem_write,
  input wire logic                                i_ext_rom_enable_bit,
  input wire strap_pin_pkg::power_state_t         i_power_state,
  // pins and straps
  input wire logic [`MEM_DATA_W-1:0]              o_mem_data_bus,
  input wire logic                                o_mem_data_bus_oe_n,
  input wire logic [`MEM_ADDR_W-1:`MEM_UPPER_LSB] o_mem_addr_upper,
  input wire logic                                o_mem_addr_bit3_oe_n,
  input wire logic                                o_mem_addr_bit2_oe_n,
  input wire logic                                o_bit3_pullup_en,
  input wire logic                                o_bit2_pulldown_en,
  input wire strap_pin_pkg::strap_t               o_straps,
  input wire strap_pin_pkg::clk_select_t          o_clk_select,
  input wire logic                                o_freq_reserved
);
  // plain slice so $past sees a signal
  wire logic [12:0] addr_up = i_mem_addr[`MEM_ADDR_W-1:`MEM_UPPER_LSB];
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RESETN);
  // low-power request, only meaningful once straps are latched
  sequence s_low_power;
    i_power_state.cpu_idle_bit && !i_power_state.wake_interrupt && i_power_state.sleep_bit;
  endsequence
  sequence s_latched;
    !o_bit3_pullup_en;
  endsequence
  chk_rom_blocks_bus: assert property (i_ext_rom_enable_bit |=> o_mem_data_bus_oe_n)
    else $error("data bus driven while rom enabled");
  chk_write_drives_bus: assert property (!i_ext_rom_enable_bit && i_mem_write
    |=> !o_mem_data_bus_oe_n && o_mem_data_bus == $past(i_mem_wdata))
    else $error("write data not on bus");
  chk_addr_follows: assert property (1'h1 |=> o_mem_addr_upper == $past(addr_up))
    else $error("upper address wrong");
  chk_pulls_drop: assert property (o_bit3_pullup_en
    |=> !o_bit3_pullup_en && !o_bit2_pulldown_en && !o_mem_addr_bit3_oe_n)
    else $error("pulls not released after capture");
  chk_straps_hold: assert property (s_latched |=> $stable(o_straps))
    else $error("latched straps moved");
  chk_clk_decode: assert property (o_clk_select == (!o_straps.clock_mode_strap ?
    strap_pin_pkg::CLK_XTAL_24 : o_straps.freq_strap == 2'h0 ? strap_pin_pkg::CLK_EXT_24 :
    o_straps.freq_strap == 2'h3 ? strap_pin_pkg::CLK_EXT_48 : strap_pin_pkg::CLK_EXT_BAD))
    else $error("clock select decode wrong");
  chk_freq_reserved: assert property (o_freq_reserved ==
    (o_straps.freq_strap == 2'h1 || o_straps.freq_strap == 2'h2))
    else $error("reserved flag wrong");
  chk_bit2_float: assert property (s_latched ##0 s_low_power ##0 o_straps.clock_mode_strap
    |=> o_mem_addr_bit2_oe_n) else $error("bit2 not floated");
  chk_bit2_awake: assert property (s_latched ##0 o_straps.clock_mode_strap
    ##0 !(i_power_state.cpu_idle_bit && !i_power_state.wake_interrupt && i_power_state.sleep_bit)
    |=> !o_mem_addr_bit2_oe_n) else $error("bit2 floated while awake");
  chk_bit2_drive: assert property (s_latched ##0 !o_straps.clock_mode_strap
    |=> !o_mem_addr_bit2_oe_n) else $error("bit2 floated in crystal mode");
endmodule : reset_strap_memory_pin_ctrl_asserts
bind reset_strap_memory_pin_ctrl reset_strap_memory_pin_ctrl_asserts chk_i (.I_CLK(I_CLK),
  .I_RESETN(I_RESETN), .i_mem_addr(i_mem_addr), .i_mem_wdata(i_mem_wdata),
  .i_mem_write(i_mem_write), .i_ext_rom_enable_bit(i_ext_rom_enable_bit),
  .i_power_state(i_power_state), .o_mem_data_bus(o_mem_data_bus),
  .o_mem_data_bus_oe_n(o_mem_data_bus_oe_n), .o_mem_addr_upper(o_mem_addr_upper),
  .o_mem_addr_bit3_oe_n(o_mem_addr_bit3_oe_n), .o_mem_addr_bit2_oe_n(o_mem_addr_bit2_oe_n),
  .o_bit3_pullup_en(o_bit3_pullup_en), .o_bit2_pulldown_en(o_bit2_pulldown_en),
  .o_straps(o_straps), .o_clk_select(o_clk_select), .o_freq_reserved(o_freq_reserved));

/* File: sim/tb_top.sv */
// self-checking bench for the memory-pin and strap controller
// assumes the bench plays the strap resistors while pins are released
`timescale 1ns/1ps
module tb_top;
  logic clk = 0, rst_n = 0, wr = 0, rom = 1, pol_s = 1, mode_s = 0;
  logic [15:0] addr = '0;
  logic [7:0]  wdata = '0, rdata, dout, din;
  logic [1:0]  low_s = '0, o_low;
  logic [12:0] up;
  logic        doe, oe3, b2, oe2, oelow, pu, pd, lpd, res;
  strap_pin_pkg::power_state_t ps = '0;
  strap_pin_pkg::strap_t       straps;
  strap_pin_pkg::clk_select_t  csel;
  int bad_count = 0, num_checks = 0;
  always #5 clk = ~clk;
  reset_strap_memory_pin_ctrl reset_strap_memory_pin_ctrl_i (.I_CLK(clk), .I_RESETN(rst_n),
    .i_mem_addr(addr), .i_mem_wdata(wdata), .i_mem_write(wr), .i_ext_rom_enable_bit(rom),
    .i_power_state(ps), .o_mem_rdata(rdata), .i_mem_data_bus(din), .o_mem_data_bus(dout),
    .o_mem_data_bus_oe_n(doe), .o_mem_addr_upper(up), .i_mem_addr_bit3(oe3 ? pol_s : up[0]),
    .o_mem_addr_bit3_oe_n(oe3), .i_mem_addr_bit2(oe2 ? mode_s : b2), .o_mem_addr_bit2(b2),
    .o_mem_addr_bit2_oe_n(oe2), .i_mem_addr_low(oelow ? low_s : o_low), .o_mem_addr_low(o_low),
    .o_mem_addr_low_oe_n(oelow), .o_bit3_pullup_en(pu), .o_bit2_pulldown_en(pd),
    .o_low_pulldown_en(lpd), .o_straps(straps), .o_clk_select(csel), .o_freq_reserved(res));
  ext_mem_model ext_mem_model_i (.i_addr(up), .i_data(dout), .i_oe_n(doe), .o_data(din));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // reset with given strap levels, then confirm capture and that it holds
  task automatic do_reset(input logic p, input logic m, input logic [1:0] f);
    @(negedge clk);
    rst_n = 0; pol_s = p; mode_s = m; low_s = f; rom = 1; wr = 0; ps = '0;
    repeat (4) @(negedge clk);
    check({pu, pd, lpd, oe3, oe2, oelow, doe}, 16'h007F);
    rst_n = 1;
    @(negedge clk);
    check(straps, {p, m, f});
    check(csel, m ? (f == 2'h0 ? 16'h1 : f == 2'h3 ? 16'h2 : 16'h3) : 16'h0);
    check(res, f == 2'h1 || f == 2'h2);
    check({pu, pd, lpd, oe3, oelow}, 16'h0000);
    // late pin activity must not reach the latches
    pol_s = !p; mode_s = !m; low_s = ~f; addr = 16'hFFFF;
    repeat (3) @(negedge clk);
    check(straps, {p, m, f});
  endtask : do_reset
  task automatic t_rw;
    @(negedge clk);
    rom = 0; addr = 16'hA5CB; wdata = 8'h3C; wr = 1;
    @(negedge clk);
    check(up, addr[15:3]);
    check({o_low, b2, oe2, doe, dout}, {addr[1:0], addr[2], 1'h0, 1'h0, wdata});
    wr = 0;
    repeat (4) @(negedge clk);
    check(rdata, addr[10:3] ^ 8'h5A);
    rom = 1; wr = 1;
    @(negedge clk);
    check(doe, 16'h1);
    wr = 0;
    $display("test done: read write");
  endtask : t_rw
  // sweep all power states; only idle, quiet, sleeping floats and only in mode 1
  task automatic t_float(input logic m);
    do_reset(1'h1, m, 2'h3);
    for (int i = 0; i < 8; i++) begin
      @(negedge clk);
      ps = i[2:0];
      @(negedge clk);
      check({oe2, b2}, {m && i == 5, addr[2]});
    end
    ps = '0;
    $display("test done: bit2 float");
  endtask : t_float
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict
  initial begin
    for (int k = 0; k < 16; k++) do_reset(k[3], k[2], k[1:0]);
    $display("test done: strap capture");
    t_rw;
    t_float(1'b1);
    t_float(1'b0);
    print_verdict;
  end
  // about three and a half times the expected run length
  initial begin
    repeat (700) @(negedge clk);
    bad_count++;
    print_verdict;
  end
endmodule : tb_top
